// File: chg_evt_pkg.sv
// package for the charger timer and temperature event block
// assumes a 20 MHz clock and a simple strobe register port
// Contract
// RULE1 - a precondition timer expiry sets the timer status when its enable and the status enable are set.
// RULE2 - a total-charge timer expiry sets the timer status when its enable and the status enable are set.
// RULE3 - the timer condition bit is 1 after a precondition or total timeout, else 0.
// RULE4 - the timer status bit reads 1 while a timer interrupt is pending and the read clears it.
// RULE5 - precondition period select 00/01/10/11 gives 40/60/80 minutes or disabled.
// RULE6 - total period select 00/01/10/11 gives 3/4/5 hours or disabled.
// RULE7 - the open-drain indicator sinks in precondition, fast-charge and top-off, else floats.
// RULE8 - charging is suspended while the hot or cold comparator is tripped.
// RULE9 - leaving the valid temperature range sets the temperature status when enabled.
// RULE10 - returning to the valid temperature range sets the temperature status when enabled.
// RULE11 - the temperature condition bit is 1 inside the valid range, 0 outside.
// RULE12 - the temperature status bit reads 1 while pending and the read clears it.
// RULE13 - a precondition expiry before the threshold is reached moves to timeout-fault.
// RULE14 - a total expiry in fast-charge or top-off moves to end-of-charge.
// RULE15 - a status bit stays set until read, and an event in the clearing cycle wins.
package chg_evt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;  // enables and period selects
  localparam logic [3:0] ADDR_STATUS = 4'h1;  // condition and sticky bits
  localparam logic [3:0] ADDR_MASK   = 4'h2;  // interrupt output mask
  localparam logic [3:0] ADDR_STATE  = 4'h3;  // charger state, read only

  // control field positions
  localparam int CTL_PRE_EN   = 0;
  localparam int CTL_TOT_EN   = 1;
  localparam int CTL_TMR_SEN  = 2;
  localparam int CTL_TOUT_EN  = 3;
  localparam int CTL_TIN_EN   = 4;
  localparam int CTL_TMP_SEN  = 5;
  localparam int CTL_PRE_SEL  = 6;   // two bits
  localparam int CTL_TOT_SEL  = 8;   // two bits
  localparam int CTL_SUSPEND  = 10;
  localparam logic [10:0] CTRL_RESET = 11'h000;

  // status field positions; mask uses the same layout
  localparam int ST_TMR_EVT = 0;
  localparam int ST_TMP_EVT = 1;
  localparam int ST_TMR_DAT = 2;
  localparam int ST_TMP_DAT = 3;
  localparam logic [1:0] MASK_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam longint CLK_HZ      = 20000000;
  localparam longint PRE40_MIN   = 40;
  localparam longint PRE60_MIN   = 60;
  localparam longint PRE80_MIN   = 80;
  localparam longint TOT3_HR     = 3;
  localparam longint TOT4_HR     = 4;
  localparam longint TOT5_HR     = 5;
  localparam longint PRE40_CYC   = PRE40_MIN * 60 * CLK_HZ;
  localparam longint PRE60_CYC   = PRE60_MIN * 60 * CLK_HZ;
  localparam longint PRE80_CYC   = PRE80_MIN * 60 * CLK_HZ;
  localparam longint TOT3_CYC    = TOT3_HR * 3600 * CLK_HZ;
  localparam longint TOT4_CYC    = TOT4_HR * 3600 * CLK_HZ;
  localparam longint TOT5_CYC    = TOT5_HR * 3600 * CLK_HZ;
  localparam int     TMR_W       = 39;
  localparam logic [1:0] SEL_OFF = 2'h3;

  // charger states
  typedef enum logic [2:0] {
    ST_SUSPEND, ST_PRECOND, ST_FAST, ST_TOPOFF, ST_EOC, ST_TEMP_FAULT, ST_TIME_FAULT
  } chg_state_t;

endpackage

// File: chg_safety_timer.sv
// one charge safety timer: a cycle counter with a selectable period
// assumes the period select is stable while the timer runs
`timescale 1ns/1ps
`default_nettype none
module chg_safety_timer
  import chg_evt_pkg::*;
#(
  parameter logic [TMR_W-1:0] P0 = TMR_W'(PRE40_CYC),
  parameter logic [TMR_W-1:0] P1 = TMR_W'(PRE60_CYC),
  parameter logic [TMR_W-1:0] P2 = TMR_W'(PRE80_CYC)
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n_sync,
  // control
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // one-cycle pulse at expiry
  output logic            expire
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             done;
    logic             expire;
  } tmr_t;

  tmr_t s_r;
  tmr_t s_nxt;
  logic [TMR_W-1:0] limit;

  // period select; code 11 never expires
  always_comb begin
    unique case (sel)
      2'h0:    limit = P0;
      2'h1:    limit = P1;
      default: limit = P2;
    endcase
  end

  // count while running, fire once, restart when run drops
  always_comb begin
    s_nxt = s_r;
    s_nxt.expire = 1'b0;
    if (!run) begin
      s_nxt.cnt  = '0;
      s_nxt.done = 1'b0;
    end else if (!s_r.done && sel != SEL_OFF) begin
      if (s_r.cnt >= limit - TMR_W'(1)) begin
        s_nxt.done   = 1'b1;
        s_nxt.expire = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + TMR_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expire = s_r.expire;

endmodule
`default_nettype wire

// File: chg_timer_temp_events.sv
// charger timer and battery temperature event logic with its registers
// assumes comparator and charger-condition inputs are asynchronous pins
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module chg_timer_temp_events
  import chg_evt_pkg::*;
#(
  parameter logic [TMR_W-1:0] PRE40 = TMR_W'(PRE40_CYC),
  parameter logic [TMR_W-1:0] PRE60 = TMR_W'(PRE60_CYC),
  parameter logic [TMR_W-1:0] PRE80 = TMR_W'(PRE80_CYC),
  parameter logic [TMR_W-1:0] TOT3  = TMR_W'(TOT3_CYC),
  parameter logic [TMR_W-1:0] TOT4  = TMR_W'(TOT4_CYC),
  parameter logic [TMR_W-1:0] TOT5  = TMR_W'(TOT5_CYC)
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // comparators on the thermistor sense pin
  input  wire logic        therm_hot,
  input  wire logic        therm_cold,
  // analog charge conditions
  input  wire logic        input_ok,
  input  wire logic        precond_reached,
  input  wire logic        term_reached,
  input  wire logic        eoc_current,
  input  wire logic        recharge_needed,
  // outputs
  output logic             charge_enable,
  output logic             charge_indicator_n_oe,
  output logic             charge_indicator_n_o,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_sync_r;
  logic       rst_n_sync;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_r[1];

  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  assign pin_raw = {therm_hot, therm_cold, input_ok, precond_reached,
                    term_reached, eoc_current, recharge_needed};

  // two stages; only the second stage is read by logic
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  logic hot_s, cold_s, in_ok_s, pre_ok_s, term_s, eoc_s, rech_s;
  assign {hot_s, cold_s, in_ok_s, pre_ok_s, term_s, eoc_s, rech_s} = pin_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // state of the block
  typedef struct packed {
    logic [10:0] ctrl;
    logic [1:0]  mask;
    logic        timer_event_status;
    logic        temp_event_status;
    logic        timer_expired_flag;
    logic        temp_in_range_flag;
    chg_state_t  state;
    logic [15:0] rdata;
    logic        charge_enable;
    logic        ind_oe;
    logic        irq;
  } evt_t;

  evt_t s_r;
  evt_t s_nxt;

  logic pre_expire;
  logic tot_expire;
  logic pre_run;
  logic tot_run;
  logic in_range;

  assign in_range = !hot_s && !cold_s;
  assign pre_run  = (s_r.state == ST_PRECOND);
  assign tot_run  = (s_r.state == ST_PRECOND) || (s_r.state == ST_FAST) ||
                    (s_r.state == ST_TOPOFF);

  ////////////////////////////////////////////////////////////////////////////
  // safety timers
  chg_safety_timer #(.P0(PRE40), .P1(PRE60), .P2(PRE80)) u_pre_tmr ( // RULE5
    .clk        (clk),
    .rst_n_sync (rst_n_sync),
    .run        (pre_run),
    .sel        (s_r.ctrl[CTL_PRE_SEL +: 2]),
    .expire     (pre_expire)
  );

  // total timer spans the whole charge cycle, reset when charging stops
  chg_safety_timer #(.P0(TOT3), .P1(TOT4), .P2(TOT5)) u_tot_tmr ( // RULE6
    .clk        (clk),
    .rst_n_sync (rst_n_sync),
    .run        (tot_run),
    .sel        (s_r.ctrl[CTL_TOT_SEL +: 2]),
    .expire     (tot_expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state: charger sequence, events, registers
  logic tmr_evt;
  logic tmp_evt;
  logic rd_status;
  logic halt;

  always_comb begin
    s_nxt = s_r;
    halt = !in_ok_s || s_r.ctrl[CTL_SUSPEND];

    // charger state machine
    unique case (s_r.state)
      ST_SUSPEND: begin
        if (!halt && in_range) begin
          s_nxt.state = ST_PRECOND;
        end
      end
      ST_PRECOND: begin
        if (pre_ok_s) begin
          s_nxt.state = ST_FAST;
        end else if (pre_expire) begin
          s_nxt.state = ST_TIME_FAULT; // RULE13
        end
      end
      ST_FAST: begin
        if (tot_expire) begin
          s_nxt.state = ST_EOC; // RULE14
        end else if (term_s) begin
          s_nxt.state = ST_TOPOFF;
        end
      end
      ST_TOPOFF: begin
        if (tot_expire || eoc_s) begin
          s_nxt.state = ST_EOC; // RULE14
        end
      end
      ST_EOC: begin
        if (rech_s) begin
          s_nxt.state = ST_PRECOND;
        end
      end
      ST_TEMP_FAULT: begin
        if (in_range) begin
          s_nxt.state = ST_SUSPEND;
        end
      end
      ST_TIME_FAULT: begin
        // leaves only through a supply loss or manual suspend
      end
    endcase
    // temperature and supply override any charging state
    if (!in_range && s_r.state != ST_TIME_FAULT) begin
      s_nxt.state = ST_TEMP_FAULT; // RULE8
    end else if (halt) begin
      s_nxt.state = ST_SUSPEND;
    end

    // condition bits
    if (pre_expire || tot_expire) begin
      s_nxt.timer_expired_flag = 1'b1; // RULE3
    end else if (s_nxt.state == ST_PRECOND && s_r.state != ST_PRECOND) begin
      s_nxt.timer_expired_flag = 1'b0; // RULE3
    end
    s_nxt.temp_in_range_flag = in_range; // RULE11

    // enabled events
    tmr_evt = s_r.ctrl[CTL_TMR_SEN] &&
              ((pre_expire && s_r.ctrl[CTL_PRE_EN]) || // RULE1
               (tot_expire && s_r.ctrl[CTL_TOT_EN]));  // RULE2
    tmp_evt = s_r.ctrl[CTL_TMP_SEN] &&
              ((s_r.temp_in_range_flag && !in_range && s_r.ctrl[CTL_TOUT_EN]) || // RULE9
               (!s_r.temp_in_range_flag && in_range && s_r.ctrl[CTL_TIN_EN]));   // RULE10

    // read clears status; a new event in the same cycle wins
    rd_status = rd && addr == ADDR_STATUS;
    if (rd_status) begin
      s_nxt.timer_event_status = 1'b0; // RULE4
      s_nxt.temp_event_status  = 1'b0; // RULE12
    end
    if (tmr_evt) begin
      s_nxt.timer_event_status = 1'b1; // RULE15
    end
    if (tmp_evt) begin
      s_nxt.temp_event_status = 1'b1; // RULE15
    end

    // register writes
    if (wr) begin
      unique case (addr)
        ADDR_CTRL: s_nxt.ctrl = wdata[10:0];
        ADDR_MASK: s_nxt.mask = wdata[1:0];
        default:   ;
      endcase
    end

    // read data for the next cycle, zero elsewhere
    s_nxt.rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        ADDR_CTRL: s_nxt.rdata = {5'h00, s_r.ctrl};
        ADDR_STATUS: begin
          s_nxt.rdata[ST_TMR_EVT] = s_r.timer_event_status; // RULE4
          s_nxt.rdata[ST_TMP_EVT] = s_r.temp_event_status;  // RULE12
          s_nxt.rdata[ST_TMR_DAT] = s_r.timer_expired_flag;
          s_nxt.rdata[ST_TMP_DAT] = s_r.temp_in_range_flag;
        end
        ADDR_MASK:  s_nxt.rdata = {14'h0000, s_r.mask};
        ADDR_STATE: s_nxt.rdata = {13'h0000, s_r.state};
        default:    ;
      endcase
    end

    // outputs, registered from the next state
    s_nxt.charge_enable = (s_nxt.state == ST_PRECOND) || (s_nxt.state == ST_FAST) ||
                          (s_nxt.state == ST_TOPOFF); // RULE8
    s_nxt.ind_oe = s_nxt.charge_enable; // RULE7
    s_nxt.irq = (s_nxt.timer_event_status && s_nxt.mask[ST_TMR_EVT]) ||
                (s_nxt.temp_event_status && s_nxt.mask[ST_TMP_EVT]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s_r.ctrl               <= CTRL_RESET;
      s_r.mask               <= MASK_RESET;
      s_r.timer_event_status <= 1'b0;
      s_r.temp_event_status  <= 1'b0;
      s_r.timer_expired_flag <= 1'b0;
      s_r.temp_in_range_flag <= 1'b0;
      s_r.state              <= ST_SUSPEND;
      s_r.rdata              <= 16'h0000;
      s_r.charge_enable      <= 1'b0;
      s_r.ind_oe             <= 1'b0;
      s_r.irq                <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // open drain: only ever drives low
  assign rdata                 = s_r.rdata;
  assign charge_enable         = s_r.charge_enable;
  assign charge_indicator_n_oe = s_r.ind_oe; // RULE7
  assign charge_indicator_n_o  = 1'b0;
  assign irq                   = s_r.irq;

endmodule
`default_nettype wire

// File: chg_evt_asserts.sv
// port-side assertions for the timer and temperature event block
// assumes a bind onto chg_timer_temp_events, seeing its ports only
`timescale 1ns/1ps
`default_nettype none
module chg_evt_asserts
  import chg_evt_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // pins
  input wire logic        therm_hot,
  input wire logic        therm_cold,
  input wire logic        charge_enable,
  input wire logic        charge_indicator_n_oe,
  input wire logic        charge_indicator_n_o,
  input wire logic        irq
);
  ////////////////////////////////////////
  logic [1:0] mask_sh_r;
  logic [3:0] tage_r;
  logic [1:0] th_prev_r;
  // mask shadow, and cycles the comparators have held still
  // an explicit previous-value register keeps this plain procedural code
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_sh_r <= 2'h0;
      tage_r <= 4'h0;
      th_prev_r <= 2'h0;
    end else begin
      if (wr && addr == ADDR_MASK) mask_sh_r <= wdata[1:0];
      th_prev_r <= {therm_hot, therm_cold};
      if ({therm_hot, therm_cold} != th_prev_r) tage_r <= 4'h0;
      else if (tage_r != 4'hf) tage_r <= tage_r + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // read data only in the cycle after a strobe
  rd_clean_a:
    assert property (!$past(rd) |-> rdata == 16'h0000) else $error("stray read data");
  unmapped_rd_a:
    assert property ($past(rd) && $past(addr) > ADDR_STATE |-> rdata == 16'h0000)
      else $error("unmapped read not zero");
  status_bits_a:
    assert property ($past(rd) && $past(addr) == ADDR_STATUS |-> rdata[15:4] == 12'h000)
      else $error("status upper bits set");
  state_code_a:
    assert property ($past(rd) && $past(addr) == ADDR_STATE |-> rdata[15:3] == 13'h0000
      && rdata[2:0] != 3'h7) else $error("bad state code");
  ind_follow_a:
    assert property (charge_indicator_n_oe == charge_enable) else $error("indicator off state");
  ind_low_a:
    assert property (charge_indicator_n_o == 1'b0) else $error("indicator drives high");
  // two sync stages plus the state register, which also holds the output, give the slack
  therm_stop_a:
    assert property ((therm_hot || therm_cold) [*5] |-> !charge_enable)
      else $error("charging while too hot or cold");
  irq_mask_a:
    assert property (irq |-> mask_sh_r != 2'h0 || $past(mask_sh_r) != 2'h0)
      else $error("irq while masked");
  temp_flag_a:
    assert property (rd && addr == ADDR_STATUS && tage_r >= 4'h8 |=>
      rdata[3] == $past(!(therm_hot || therm_cold))) else $error("range flag wrong");
endmodule
bind chg_timer_temp_events chg_evt_asserts u_chk (.clk(clk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .therm_hot(therm_hot),
  .therm_cold(therm_cold), .charge_enable(charge_enable),
  .charge_indicator_n_oe(charge_indicator_n_oe),
  .charge_indicator_n_o(charge_indicator_n_o), .irq(irq));
`default_nettype wire

// File: cell_env.sv
// thermistor comparators of the analog side, set by a temperature code
// assumes code 0 in range, 1 hot, 2 cold, chosen by the bench
`timescale 1ns/1ps
`default_nettype none
module cell_env (
  // clock
  input  wire logic       clk,
  // temperature code
  input  wire logic [1:0] temp,
  // comparator outputs
  output logic            therm_hot,
  output logic            therm_cold
);
  logic [1:0] temp_r = 2'h0;
  // pins move just after an edge; one code so both never trip together
  always @(posedge clk) temp_r <= temp;
  assign therm_hot = (temp_r == 2'h1);
  assign therm_cold = (temp_r == 2'h2);
endmodule
`default_nettype wire

// File: test_charger_timer_temp_events.sv
// self-checking bench for the timer and temperature event block
// assumes short timer counts and the analog model in cell_env
`timescale 1ns/1ps
`default_nettype none
module test_charger_timer_temp_events
  import chg_evt_pkg::*;
;
  ////////////////////////////////////////
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [1:0]  temp = 2'h0;
  logic        input_ok = 1'b0;
  logic        pre_ok = 1'b0;
  logic        term = 1'b0;
  logic [15:0] rdata;
  logic [15:0] d;
  logic        therm_hot;
  logic        therm_cold;
  logic        chg_en;
  logic        ind_oe;
  logic        irq;
  int          error_cnt = 0;
  int          num_checks = 0;
  // 50 ns period
  initial forever #25 clk = ~clk;
  // counts shortened so the whole run stays brief
  chg_timer_temp_events #(.PRE40(TMR_W'(20)), .PRE60(TMR_W'(30)), .PRE80(TMR_W'(40)),
    .TOT3(TMR_W'(100)), .TOT4(TMR_W'(120)), .TOT5(TMR_W'(140))) DUT (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .therm_hot(therm_hot), .therm_cold(therm_cold),
    .input_ok(input_ok), .precond_reached(pre_ok), .term_reached(term),
    .eoc_current(1'b0), .recharge_needed(1'b0), .charge_enable(chg_en),
    .charge_indicator_n_oe(ind_oe), .charge_indicator_n_o(), .irq(irq));
  cell_env ENV (.clk(clk), .temp(temp), .therm_hot(therm_hot), .therm_cold(therm_cold));
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // masked compare of any result
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
    num_checks++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h want %h", $time, g & m, e & m);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // lo below zero means irq must stay low for hi cycles
  task automatic wirq(input int lo, input int hi);
    int n;
    n = 0;
    // look between edges, where the registered irq has settled
    while (irq !== 1'b1 && n < hi) begin
      @(negedge clk);
      n++;
    end
    if (lo < 0) chk({15'h0, irq}, 16'h0000, 16'h0001);
    else chk({15'h0, irq === 1'b1 && n >= lo}, 16'h0001, 16'h0001);
    // only a missing irq ends the run early; one that lands on the bound is fine
    if (lo >= 0 && irq !== 1'b1) end_sim();
  endtask
  // a manual suspend restarts the cycle, so each run starts clean
  task automatic run_tmr(input logic [15:0] c, input int lo, input int hi,
                         input logic [15:0] st, input logic [15:0] sv);
    wr_reg(ADDR_CTRL, c | 16'h0400);
    repeat (3) @(posedge clk);
    wr_reg(ADDR_CTRL, c);
    wirq(lo, hi);
    rd_reg(ADDR_STATE, d);
    chk(d, st, 16'h0007);
    chk({15'h0, ind_oe}, {15'h0, st != 16'h0 && st < 16'h4}, 16'h0001);
    rd_reg(ADDR_STATUS, d);
    chk(d, sv, 16'h0005);
    rd_reg(ADDR_STATUS, d);
    chk(d, 16'h0000, 16'h0001);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(ADDR_CTRL, d);
    chk(d, 16'h0000, 16'h07ff);
    rd_reg(ADDR_MASK, d);
    chk(d, 16'h0000, 16'h0003);
    rd_reg(ADDR_STATE, d);
    chk(d, 16'h0000, 16'hffff);
    rd_reg(4'h9, d);
    chk(d, 16'h0000, 16'hffff);
    wr_reg(ADDR_MASK, 16'h0003);
    rd_reg(ADDR_MASK, d);
    chk(d, 16'h0003, 16'h0003);
    @(posedge clk);
    input_ok <= 1'b1;
    // precondition periods, total timer off, cell never reaches threshold
    run_tmr(16'h0305, 19, 35, 16'h6, 16'h5);
    run_tmr(16'h0345, 29, 45, 16'h6, 16'h5);
    run_tmr(16'h0385, 39, 55, 16'h6, 16'h5);
    run_tmr(16'h03c5, -1, 60, 16'h1, 16'h0);
    run_tmr(16'h0304, -1, 60, 16'h6, 16'h4);
    @(posedge clk);
    pre_ok <= 1'b1;
    // total periods, precondition timer off
    run_tmr(16'h00c6, 99, 120, 16'h4, 16'h5);
    run_tmr(16'h01c6, 119, 140, 16'h4, 16'h5);
    run_tmr(16'h02c6, 139, 160, 16'h4, 16'h5);
    run_tmr(16'h03c6, -1, 160, 16'h2, 16'h0);
    // total expiry caught in top-off rather than fast-charge
    @(posedge clk);
    term <= 1'b1;
    run_tmr(16'h00c6, 99, 120, 16'h4, 16'h5);
    // temperature window, leave edge only
    wr_reg(ADDR_CTRL, 16'h03e8);
    @(posedge clk);
    temp <= 2'h1;
    wirq(0, 12);
    rd_reg(ADDR_STATUS, d);
    chk(d, 16'h0002, 16'h000a);
    rd_reg(ADDR_STATE, d);
    chk(d, 16'h0005, 16'h0007);
    chk({15'h0, chg_en}, 16'h0000, 16'h0001);
    rd_reg(ADDR_STATUS, d);
    chk(d, 16'h0000, 16'h0002);
    // return edge only
    wr_reg(ADDR_CTRL, 16'h03f0);
    @(posedge clk);
    temp <= 2'h0;
    wirq(0, 12);
    rd_reg(ADDR_STATUS, d);
    chk(d, 16'h000a, 16'h000a);
    // event still latched while its irq is masked off
    wr_reg(ADDR_MASK, 16'h0001);
    wr_reg(ADDR_CTRL, 16'h03f8);
    @(posedge clk);
    temp <= 2'h2;
    wirq(-1, 12);
    rd_reg(ADDR_STATUS, d);
    chk(d, 16'h0002, 16'h000a);
    // return event lands on the clearing read edge: pin, env, two syncs, status
    @(posedge clk);
    temp <= 2'h0;
    repeat (2) @(posedge clk);
    rd_reg(ADDR_STATUS, d);
    chk(d, 16'h0000, 16'h000a);
    rd_reg(ADDR_STATUS, d);
    chk(d, 16'h000a, 16'h000a);
    end_sim();
  end
endmodule
`default_nettype wire
